/* File: host_sink.sv */
/* Host side model: drains the report byte stream.
   Assumes the bench clock; stall_mode picks ready, random or long stalls. */
`timescale 1ns/10ps
`default_nettype none
module host_sink (
  input wire logic clock,
  input wire logic [1:0] stall_mode,
  output var logic out_ready
);
  int seed = 32'h1234ABCD;
  logic [5:0] tick = 6'h00;
  initial out_ready = 1'b1;
  // ==========
  // ready pattern; long stalls fill the framer's buffer
  // every packet is drained, none refused
  always @(negedge clock) begin
    tick <= tick + 6'h01;
    case (stall_mode)
      2'h0: out_ready <= 1'b1;
      2'h1: out_ready <= |2'($random(seed));
      default: out_ready <= tick[5];
    endcase
  end
endmodule // host_sink
`default_nettype wire

/* File: sat_report_checker_sva.sv */
/* Port checker for the satellite report framer.
   Assumes it is bound to the framer and sees only that module's ports. */
`timescale 1ns/10ps
`default_nettype none
module sat_report_checker #(
  parameter int SEC_CYCLES = 10,
  parameter int ELEV_SECONDS = 15
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic eph_request,
  input wire logic [7:0] eph_request_sat,
  input wire logic trk_request,
  input wire logic [7:0] trk_request_sat,
  input wire logic eph_new,
  input wire logic busy,
  input wire logic [7:0] query_sat,
  input wire logic query_kind,
  input wire logic elev_refresh,
  input wire logic azim_refresh,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [7:0] out_data,
  input wire logic out_first,
  input wire logic out_last,
  input wire logic out_is_tracking
);
  localparam int ELEV_P = SEC_CYCLES * ELEV_SECONDS;
  logic [4:0] idx;
  logic seen;
  int gap;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========
  // byte index in packet, cycles since elevation refresh
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 5'h00;
      seen <= 1'b0;
      gap <= 0;
    end else begin
      if (out_valid && out_ready)
        idx <= out_last ? 5'h00 : idx + 5'h01;
      seen <= seen | elev_refresh;
      gap <= elev_refresh ? 0 : gap + 1;
    end
  end
  // ==========
  // assertions
  chk_first_sat:
    assert property (out_valid && out_first |-> out_data >= 8'h01 && out_data <= 8'h20)
    else $error("first byte is not a satellite number");
  chk_eph_take:
    assert property (eph_request && eph_request_sat inside {[8'h01:8'h20]} && !busy
      && !$past(busy) && !$past(eph_request || eph_new || trk_request)
      |-> ##2 busy && !query_kind && query_sat == $past(eph_request_sat, 2))
    else $error("ephemeris request not taken");
  chk_trk_take:
    assert property (trk_request && trk_request_sat inside {[8'h01:8'h20]} && !busy
      && !eph_request && !eph_new && !$past(busy)
      && !$past(eph_request || eph_new || trk_request)
      |-> ##2 busy && query_kind && query_sat == $past(trk_request_sat, 2))
    else $error("tracking request not taken");
  chk_first_delay:
    assert property ($rose(busy) && !out_valid |-> ##2 out_valid && out_first)
    else $error("first byte late");
  chk_stall_hold:
    assert property (out_valid && !out_ready |=> out_valid && $stable(out_data)
      && $stable(out_last))
    else $error("byte changed during stall");
  chk_last_count:
    assert property (out_valid && out_last |-> idx == (out_is_tracking ? 5'h17 : 5'h0F))
    else $error("packet length wrong");
  chk_slot_code:
    assert property (out_valid && out_is_tracking && idx == 5'h01 |-> out_data[2:0] <= 3'h5)
    else $error("slot code out of range");
  chk_msec_code:
    assert property (out_valid && out_is_tracking && idx == 5'h15 |-> out_data <= 8'h04)
    else $error("msec flag code unknown");
  chk_elev_gap:
    assert property (elev_refresh && seen |-> gap == ELEV_P - 1)
    else $error("elevation refresh spacing wrong");
  chk_elev_late:
    assert property (seen |-> gap < ELEV_P)
    else $error("elevation refresh missing");
  cov_trk_done: cover property (out_valid && out_ready && out_last && out_is_tracking);
  cov_full_stall: cover property (busy && out_valid && !out_ready);
  cov_azim: cover property (azim_refresh);
endmodule // sat_report_checker
bind sat_status_report_packets sat_report_checker #(
  .SEC_CYCLES(SEC_CYCLES), .ELEV_SECONDS(ELEV_SECONDS)) chk (
  .clock(clock), .rst_n(rst_n), .eph_request(eph_request), .eph_request_sat(eph_request_sat),
  .trk_request(trk_request), .trk_request_sat(trk_request_sat), .eph_new(eph_new),
  .busy(busy), .query_sat(query_sat), .query_kind(query_kind), .elev_refresh(elev_refresh),
  .azim_refresh(azim_refresh), .out_valid(out_valid), .out_ready(out_ready),
  .out_data(out_data), .out_first(out_first), .out_last(out_last),
  .out_is_tracking(out_is_tracking));
`default_nettype wire

/* File: sat_report_map.vh */
/*
  Constants for the satellite status report framer: report codes, byte counts,
  field encodings, float constants and timing counts.
  Assumes inclusion by bare name from the framer source.
*/
`ifndef SAT_REPORT_MAP_VH
`define SAT_REPORT_MAP_VH

// ==========================================================
// report identifiers and sizes
`define EPH_REPORT_ID 8'h5B
`define TRK_REPORT_ID 8'h5C
`define EPH_REPORT_BYTES 5'h10
`define TRK_REPORT_BYTES 5'h18

// ==========================================================
// satellite number range
`define SAT_NUMBER_MIN 8'h01
`define SAT_NUMBER_MAX 8'h20

// ==========================================================
// flag byte encodings
`define FLAG_CLEAR 8'h00
`define FLAG_SET 8'h01
`define MSEC_UNKNOWN 3'h0
`define MSEC_SUSPECT 3'h4
`define SLOT_LAST 3'h5
`define CHANNEL_COUNT 8'h06
// single-precision -1.0, sent as the time when nothing was measured
`define MEAS_NONE_TIME 32'hBF800000

// ==========================================================
// timing
`define CLOCK_HZ 200000000
`define ELEV_REFRESH_S 15
`define AZIM_REFRESH_S 240

`endif

/* File: sat_status_report_packets.v */
/*
  Framer for the satellite ephemeris status and tracking status reports.
  Assumes the receiver core answers query_sat/query_kind with stable field
  inputs in the cycle query_sat is shown, and drains bytes by valid/ready.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sat_report_map.vh"
// Contract
// [RQ1] ephemeris report on host request and on changed issue number
// [RQ2] ephemeris report order: sat, time, health, issue, ref time, fit, accuracy
// [RQ3] satellite number byte only 1 to 32
// [RQ4] collection time is GPS seconds when ephemeris gathered
// [RQ5] health carries 6-bit value; accuracy code converted to meters
// [RQ6] tracking report for requested satellite, first byte satellite number
// [RQ7] byte 1 bits 2..0 slot code, 000..101 for slots 1..6
// [RQ8] byte 1 bits 7..3 zero-based channel number
// [RQ9] ephemeris flag zero clear, nonzero good young healthy ephemeris
// [RQ10] measurement time negative when never measured, else last center time
// [RQ11] elevation in radians, refreshed about every 15 seconds
// [RQ12] azimuth in radians from north, refreshed every 3 to 5 minutes
// [RQ13] old-measurement flag zero clear, nonzero too old for fix
// [RQ14] msec flag codes 0 to 4 as listed
// [RQ15] data-collect flag zero clear, nonzero collecting now
// [RQ16] host treats unknown codes as unknown, keeps packet
module sat_status_report_packets #(
  parameter SEC_CYCLES = `CLOCK_HZ,
  parameter ELEV_SECONDS = `ELEV_REFRESH_S,
  parameter AZIM_SECONDS = `AZIM_REFRESH_S,
  parameter WORD_WIDTH = 11
) (
  input wire clock,
  input wire rst_n,
  input wire eph_request,
  input wire [7:0] eph_request_sat,
  input wire trk_request,
  input wire [7:0] trk_request_sat,
  input wire eph_new,
  input wire [7:0] eph_new_sat,
  input wire [7:0] eph_new_issue,
  input wire [31:0] eph_collect_time,
  input wire [5:0] eph_health,
  input wire [7:0] ephemeris_issue_number,
  input wire [31:0] eph_ref_time,
  input wire [7:0] eph_fit_interval,
  input wire [3:0] eph_accuracy_code,
  input wire [7:0] trk_channel,
  input wire [2:0] trk_slot,
  input wire [7:0] trk_acq_flag,
  input wire trk_eph_good,
  input wire [31:0] trk_signal_level,
  input wire trk_meas_taken,
  input wire [31:0] trk_meas_time,
  input wire [31:0] trk_elevation,
  input wire [31:0] trk_azimuth,
  input wire trk_meas_old,
  input wire [2:0] trk_msec_state,
  input wire [7:0] trk_bad_data_flag,
  input wire trk_collecting,
  output reg [7:0] query_sat,
  output reg query_kind,
  output reg elev_refresh,
  output reg azim_refresh,
  output reg busy,
  output reg out_valid,
  input wire out_ready,
  output reg [7:0] out_data,
  output reg out_first,
  output reg out_last,
  output reg out_is_tracking
);

  localparam S_IDLE = 2'h0;
  localparam S_FETCH = 2'h1;
  localparam S_SEND = 2'h2;

  // ==========================================================
  // reset release; all other state except issue_mem resets on this copy, asserted at once, freed on an edge
  reg rst_meta, rst_sync;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {rst_meta, rst_sync} <= 2'b00;
    end else begin
      {rst_sync, rst_meta} <= {rst_meta, 1'b1};
    end
  end

  function sat_ok;
    input [7:0] s;
    begin
      sat_ok = (s >= `SAT_NUMBER_MIN) && (s <= `SAT_NUMBER_MAX);
    end
  endfunction

  function [31:0] accuracy_meters;
    input [3:0] code;
    begin
      case (code)
        4'h0: accuracy_meters = 32'h40000000;
        4'h1: accuracy_meters = 32'h40333333;
        4'h2: accuracy_meters = 32'h40800000;
        4'h3: accuracy_meters = 32'h40B66666;
        4'h4: accuracy_meters = 32'h41000000;
        4'h5: accuracy_meters = 32'h4134CCCD;
        4'h6: accuracy_meters = 32'h41800000;
        4'h7: accuracy_meters = 32'h42000000;
        4'h8: accuracy_meters = 32'h42800000;
        4'h9: accuracy_meters = 32'h43000000;
        4'hA: accuracy_meters = 32'h43800000;
        4'hB: accuracy_meters = 32'h44000000;
        4'hC: accuracy_meters = 32'h44800000;
        4'hD: accuracy_meters = 32'h45000000;
        4'hE: accuracy_meters = 32'h45800000;
        default: accuracy_meters = 32'h45C00000;
      endcase
    end
  endfunction

  // ==========================================================
  // refresh pacing for elevation and azimuth
  reg [31:0] sec_count;
  reg [7:0] elev_secs, azim_secs;
  wire sec_tick = (sec_count == SEC_CYCLES - 1);
  always @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      sec_count <= 32'h00000000;
      {elev_secs, azim_secs} <= 16'h0000;
      {elev_refresh, azim_refresh} <= 2'b00;
    end else begin
      sec_count <= sec_tick ? 32'h00000000 : sec_count + 32'h00000001;
      // [RQ11] elevation refresh pulse
      elev_refresh <= sec_tick && (elev_secs == ELEV_SECONDS - 1);
      // [RQ12] azimuth refresh pulse
      azim_refresh <= sec_tick && (azim_secs == AZIM_SECONDS - 1);
      if (sec_tick) begin
        elev_secs <= (elev_secs == ELEV_SECONDS - 1) ? 8'h00 : elev_secs + 8'h01;
        azim_secs <= (azim_secs == AZIM_SECONDS - 1) ? 8'h00 : azim_secs + 8'h01;
      end
    end
  end

  // ==========================================================
  // issue-number memory and pending requests
  reg [7:0] issue_mem [0:31];
  reg [31:0] issue_known;
  reg pend_eph, pend_new, pend_trk;
  reg [7:0] pend_eph_sat, pend_new_sat, pend_trk_sat;
  reg [1:0] state;
  reg [4:0] remain;
  reg [191:0] shifter;
  reg gen_first;
  wire [4:0] new_idx = eph_new_sat[4:0] - 5'h01;
  wire new_changed = !issue_known[new_idx] || (issue_mem[new_idx] != eph_new_issue);
  wire take_eph = (state == S_IDLE) && pend_eph;
  wire take_new = (state == S_IDLE) && !pend_eph && pend_new;
  wire take_trk = (state == S_IDLE) && !pend_eph && !pend_new && pend_trk;

  always @(posedge clock) begin
    if (eph_new && sat_ok(eph_new_sat))
      issue_mem[new_idx] <= eph_new_issue;
  end

  always @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      issue_known <= 32'h00000000;
      {pend_eph, pend_new, pend_trk} <= 3'b000;
      {pend_eph_sat, pend_new_sat, pend_trk_sat} <= 24'h000000;
    end else begin
      // [RQ1] host request; a new request wins over the take
      // [RQ3] out-of-range satellite numbers never start a report
      if (eph_request && sat_ok(eph_request_sat)) begin
        pend_eph <= 1'b1;
        pend_eph_sat <= eph_request_sat;
      end else if (take_eph) begin
        pend_eph <= 1'b0;
      end
      // [RQ1] spontaneous report on changed issue number
      if (eph_new && sat_ok(eph_new_sat) && new_changed) begin
        pend_new <= 1'b1;
        pend_new_sat <= eph_new_sat;
      end else if (take_new) begin
        pend_new <= 1'b0;
      end
      if (eph_new && sat_ok(eph_new_sat))
        issue_known[new_idx] <= 1'b1;
      // [RQ6] tracking report for the requested satellite
      if (trk_request && sat_ok(trk_request_sat)) begin
        pend_trk <= 1'b1;
        pend_trk_sat <= trk_request_sat;
      end else if (take_trk) begin
        pend_trk <= 1'b0;
      end
    end
  end

  // ==========================================================
  // report assembly
  reg [7:0] chan_slot;
  reg [2:0] msec_code;
  always @* begin
    // [RQ8] zero-based channel; unknown channels sent as code of channel 1
    if (trk_channel >= 8'h01 && trk_channel <= `CHANNEL_COUNT)
      chan_slot[7:3] = trk_channel[4:0] - 5'h01;
    else
      chan_slot[7:3] = 5'h00;
    // [RQ7] slot code, saturated at slot 6
    chan_slot[2:0] = (trk_slot > `SLOT_LAST) ? `SLOT_LAST : trk_slot;
    // [RQ14] codes above suspected error become unknown
    msec_code = (trk_msec_state > `MSEC_SUSPECT) ? `MSEC_UNKNOWN : trk_msec_state;
  end

  wire [WORD_WIDTH-1:0] gen_word = {query_kind, gen_first, remain == 5'h01, shifter[191:184]};
  reg [WORD_WIDTH-1:0] entry1;
  reg valid1;
  wire push = (state == S_SEND) && !valid1;
  wire pop = out_valid && out_ready;

  always @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= S_IDLE;
      remain <= 5'h00;
      shifter <= 192'h0;
      query_sat <= 8'h00;
      {query_kind, busy, gen_first} <= 3'b000;
    end else begin
      case (state)
        S_IDLE: begin
          if (take_eph || take_new || take_trk) begin
            query_sat <= take_eph ? pend_eph_sat : (take_new ? pend_new_sat : pend_trk_sat);
            query_kind <= take_trk;
            busy <= 1'b1;
            state <= S_FETCH;
          end
        end
        S_FETCH: begin
          gen_first <= 1'b1;
          if (!query_kind) begin
            remain <= `EPH_REPORT_BYTES;
            // [RQ2] field order; [RQ4] collection time; [RQ5] health and accuracy
            shifter <= {query_sat, eph_collect_time, 2'b00, eph_health,
                        ephemeris_issue_number, eph_ref_time, eph_fit_interval,
                        accuracy_meters(eph_accuracy_code), 64'h0};
          end else begin
            remain <= `TRK_REPORT_BYTES;
            // [RQ9] [RQ13] [RQ15] flag bytes; [RQ10] negative time if unmeasured
            shifter <= {query_sat, chan_slot, trk_acq_flag,
                        trk_eph_good ? `FLAG_SET : `FLAG_CLEAR, trk_signal_level,
                        trk_meas_taken ? trk_meas_time : `MEAS_NONE_TIME,
                        trk_elevation, trk_azimuth,
                        trk_meas_old ? `FLAG_SET : `FLAG_CLEAR, 5'h00, msec_code,
                        trk_bad_data_flag, trk_collecting ? `FLAG_SET : `FLAG_CLEAR};
          end
          state <= S_SEND;
        end
        S_SEND: begin
          if (push) begin
            gen_first <= 1'b0;
            shifter <= {shifter[183:0], 8'h00};
            remain <= remain - 5'h01;
            if (remain == 5'h01) begin
              busy <= 1'b0;
              state <= S_IDLE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // two-entry output buffer; entry 0 drives the ports directly
  always @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      {out_valid, valid1} <= 2'b00;
      entry1 <= {WORD_WIDTH{1'b0}};
      {out_is_tracking, out_first, out_last, out_data} <= {WORD_WIDTH{1'b0}};
    end else begin
      if (pop && valid1) begin
        {out_is_tracking, out_first, out_last, out_data} <= entry1;
        valid1 <= 1'b0;
      end else if (pop) begin
        out_valid <= push;
        if (push)
          {out_is_tracking, out_first, out_last, out_data} <= gen_word;
      end else if (push && !out_valid) begin
        out_valid <= 1'b1;
        {out_is_tracking, out_first, out_last, out_data} <= gen_word;
      end else if (push) begin
        valid1 <= 1'b1;
        entry1 <= gen_word;
      end
    end
  end

endmodule // sat_status_report_packets
`default_nettype wire

/* File: sat_status_report_packets_bench.sv */
/* Testbench for the satellite report framer.
   Assumes host_sink drains bytes; the bench plays the receiver core. */
`timescale 1ns/10ps
`default_nettype none
module sat_status_report_packets_bench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic eph_request = 1'b0;
  logic trk_request = 1'b0;
  logic eph_new = 1'b0;
  logic [7:0] sat = 8'h00, s = 8'h00, iss = 8'h00, fit = 8'h00;
  logic [7:0] chan = 8'h01, acq = 8'h00, bad = 8'h00;
  logic [31:0] ct = 32'h0, rt = 32'h0, sig = 32'h0, mt = 32'h0, el = 32'h0, az = 32'h0;
  logic [5:0] hl = 6'h00;
  logic [2:0] slot = 3'h0, msec = 3'h0;
  logic eg = 1'b0, mtk = 1'b0, old = 1'b0, col = 1'b0;
  logic [3:0] acc = 4'hF;
  logic [1:0] mode = 2'h0;
  wire [7:0] query_sat, out_data;
  wire query_kind, elev_refresh, azim_refresh, busy, out_valid, out_ready;
  wire out_first, out_last, out_is_tracking;
  logic [7:0] got[$];
  int seed = 32'h397C66FE;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int i;
  sat_status_report_packets #(.SEC_CYCLES(10)) dut (
    .clock(clock), .rst_n(rst_n), .eph_request(eph_request), .eph_request_sat(sat),
    .trk_request(trk_request), .trk_request_sat(sat), .eph_new(eph_new), .eph_new_sat(sat),
    .eph_new_issue(iss), .eph_collect_time(ct), .eph_health(hl), .ephemeris_issue_number(iss),
    .eph_ref_time(rt), .eph_fit_interval(fit), .eph_accuracy_code(acc), .trk_channel(chan),
    .trk_slot(slot), .trk_acq_flag(acq), .trk_eph_good(eg), .trk_signal_level(sig),
    .trk_meas_taken(mtk), .trk_meas_time(mt), .trk_elevation(el), .trk_azimuth(az),
    .trk_meas_old(old), .trk_msec_state(msec), .trk_bad_data_flag(bad), .trk_collecting(col),
    .query_sat(query_sat), .query_kind(query_kind), .elev_refresh(elev_refresh),
    .azim_refresh(azim_refresh), .busy(busy), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .out_first(out_first), .out_last(out_last),
    .out_is_tracking(out_is_tracking));
  host_sink partner (.clock(clock), .stall_mode(mode), .out_ready(out_ready));
  initial forever #2.5 clock = ~clock;
  // ==========
  // byte capture and hang guard
  always @(posedge clock) begin
    if (out_valid && out_ready)
      got.push_back(out_data);
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict;
    end
  end
  task check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [31:0] acc_m(input logic [3:0] a);
    logic [31:0] t [0:15];
    t = '{32'h40000000, 32'h40333333, 32'h40800000, 32'h40B66666,
          32'h41000000, 32'h4134CCCD, 32'h41800000, 32'h42000000,
          32'h42800000, 32'h43000000, 32'h43800000, 32'h44000000,
          32'h44800000, 32'h45000000, 32'h45800000, 32'h45C00000};
    return t[a];
  endfunction
  function automatic logic [7:0] exp_byte(input logic t, input int k, input logic [7:0] q);
    logic [7:0] c;
    logic [2:0] sl;
    logic [2:0] ms;
    logic [191:0] v;
    // out-of-range inputs: channel 1 code, slot 6, msec unknown
    c = (chan >= 8'h01 && chan <= 8'h06) ? chan - 8'h01 : 8'h00;
    sl = (slot > 3'h5) ? 3'h5 : slot;
    ms = (msec > 3'h4) ? 3'h0 : msec;
    v = t ? {q, c[4:0], sl, acq, 7'h00, eg, sig, mtk ? mt : 32'hBF800000, el, az,
             7'h00, old, 5'h00, ms, bad, 7'h00, col}
          : {q, ct, 2'h0, hl, iss, rt, fit, acc_m(acc), 64'h0};
    return v[191 - 8 * k -: 8];
  endfunction
  task expect_pkt(input logic t, input logic [7:0] q);
    int n;
    int k;
    n = t ? 24 : 16;
    k = 0;
    while (got.size() < n && k < 400) begin
      @(negedge clock);
      k++;
    end
    check("report length", 8'h01, {7'h00, got.size() >= n});
    for (k = 0; k < n && got.size() > 0; k++)
      check("report byte", exp_byte(t, k, q), got.pop_front());
  endtask
  task req(input logic [2:0] m, input logic [7:0] q);
    @(negedge clock);
    {eph_new, trk_request, eph_request} = m;
    sat = q;
    @(negedge clock);
    {eph_new, trk_request, eph_request} = 3'h0;
  endtask
  task quiet;
    repeat (20) @(negedge clock);
    check("stray bytes", 8'h00, 8'(got.size()));
    check("busy", 8'h00, {7'h00, busy});
  endtask
  task rnd;
    ct = $random(seed);
    rt = $random(seed);
    sig = $random(seed);
    mt = $random(seed);
    el = $random(seed);
    az = $random(seed);
    {hl, eg, mtk} = 8'($random(seed));
    {iss, fit, acq, bad} = $random(seed);
    {old, col} = 2'($random(seed));
    acc = 4'($random(seed));
    chan = 8'h01 + 8'($unsigned($random(seed)) % 6);
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    for (i = 0; i < 12; i++) begin
      rnd;
      mode = 2'(i % 3);
      slot = 3'(i % 6);
      msec = 3'(i % 5);
      s = (i < 2) ? (i ? 8'h20 : 8'h01) : 8'h01 + 8'($unsigned($random(seed)) % 32);
      req(i[0] ? 3'h2 : 3'h1, s);
      expect_pkt(i[0], s);
    end
    req(3'h3, 8'h00);
    req(3'h3, 8'h21);
    quiet;
    // same issue twice must not repeat the spontaneous report
    rnd;
    req(3'h4, 8'h07);
    expect_pkt(1'b0, 8'h07);
    req(3'h4, 8'h07);
    quiet;
    iss = iss + 8'h01;
    req(3'h4, 8'h07);
    expect_pkt(1'b0, 8'h07);
    mode = 2'h2;
    req(3'h3, 8'h11);
    expect_pkt(1'b0, 8'h11);
    expect_pkt(1'b1, 8'h11);
    chan = 8'h09;
    slot = 3'h7;
    msec = 3'h6;
    req(3'h2, 8'h20);
    expect_pkt(1'b1, 8'h20);
    quiet;
    repeat (2500) @(negedge clock);
    give_verdict;
  end
endmodule // sat_status_report_packets_bench
`default_nettype wire
